// *** rtl/cacr_regs.svh ***
`ifndef CACR_REGS_SVH
`define CACR_REGS_SVH
// serial port framing
`define CACR_ADDR_W 15
`define CACR_RW_BIT 15
`define CACR_CMD_BITS 5'h10
`define CACR_DATA_BITS 5'h08
// byte offsets
`define CACR_OFF_SYNC_POS0 15'h002c
`define CACR_OFF_SYNC_POS1 15'h002d
`define CACR_OFF_SYNC_POS2 15'h002e
`define CACR_OFF_FSA_LO 15'h0030
`define CACR_OFF_FSA_HI 15'h0031
`define CACR_OFF_FSB_LO 15'h0032
`define CACR_OFF_FSB_HI 15'h0033
`define CACR_OFF_REFSEL 15'h0038
`define CACR_OFF_TSCTRL 15'h003b
`define CACR_OFF_EMPH 15'h0048
// reset values
`define CACR_FS_RESET 16'ha000
`define CACR_BIT_RESET 1'h0
`define CACR_LVL_RESET 3'h0
`define CACR_POS_RESET 24'h000000
// field positions
`define CACR_REFSEL_BIT 0
`define CACR_TS_EN_BIT 0
`define CACR_TS_PECL_BIT 1
`define CACR_EMPH_LVL_MSB 2
`define CACR_EMPH_LVL_LSB 0
`define CACR_EMPH_BOOST_BIT 3
// lanes fed by the emphasis setting
`define CACR_LANES 16
`endif

// *** rtl/cacr_pkg.sv ***
package cacr_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_cmd = 2'b01,
    st_data = 2'b10
  } cacr_state_e;

  typedef struct packed {
    logic [15:0] input_a_full_scale;
    logic [15:0] input_b_full_scale;
    logic reference_source_select;
    logic timestamp_receiver_enable;
    logic timestamp_pecl_mode;
    logic lane_emphasis_boost;
    logic [2:0] lane_emphasis_level;
  } cacr_ctrl_s;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } cacr_pins_s;
endpackage

// *** rtl/cacr_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module cacr_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous pins in, synchronised copies out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;

  // first stage is read only by the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        next_meta[i] = din[i];
        next_dout[i] = meta[i];
      end
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta[i] <= RST_VAL[i];
          dout[i] <= RST_VAL[i];
        end else begin
          meta[i] <= next_meta[i];
          dout[i] <= next_dout[i];
        end
      end
    end
  endgenerate
endmodule // cacr_pin_sync
`default_nettype wire

// *** rtl/cacr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cacr_regs.svh"
module cacr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial control port pins
  input wire logic sclk,
  input wire logic scs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // sync edge measurement
  input wire logic sync_pos_strobe,
  input wire logic [23:0] sync_pos_value,
  output logic sync_pos_valid,
  // analog and lane controls
  output cacr_pkg::cacr_ctrl_s ctrl,
  output logic [4*`CACR_LANES-1:0] lane_emphasis
);
  import cacr_pkg::*;

  cacr_pins_s pins_raw;
  cacr_pins_s pins;
  logic sclk_prev;
  logic rise;
  logic fall;
  cacr_state_e state;
  cacr_state_e next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [`CACR_ADDR_W-1:0] addr;
  logic [`CACR_ADDR_W-1:0] next_addr;
  logic rw;
  logic next_rw;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic next_sdo;
  logic next_sdo_oe;
  cacr_ctrl_s next_ctrl;
  logic [23:0] pos;
  logic [23:0] next_pos;
  logic next_pos_valid;
  logic wr_commit;
  logic [7:0] wdata;
  logic [`CACR_ADDR_W-1:0] cmd_addr;

  // idle levels: clock low, select high
  assign pins_raw = '{sclk: sclk, cs_n: scs_n, sdi: sdi};

  cacr_pin_sync #(
    .W($bits(cacr_pins_s)),
    .RST_VAL(3'h2)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(pins_raw),
    .dout(pins)
  );

  // edges seen two clocks late, so serial clock must stay well below clk/8
  assign rise = pins.sclk & ~sclk_prev & ~pins.cs_n;
  assign fall = ~pins.sclk & sclk_prev & ~pins.cs_n;
  assign cmd_addr = {shift[13:0], pins.sdi};

  function automatic logic [7:0] rd_byte(input logic [`CACR_ADDR_W-1:0] a, input cacr_ctrl_s c,
                                          input logic [23:0] p);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `CACR_OFF_SYNC_POS0: d = p[7:0];
      `CACR_OFF_SYNC_POS1: d = p[15:8];
      `CACR_OFF_SYNC_POS2: d = p[23:16];
      `CACR_OFF_FSA_LO: d = c.input_a_full_scale[7:0];
      `CACR_OFF_FSA_HI: d = c.input_a_full_scale[15:8];
      `CACR_OFF_FSB_LO: d = c.input_b_full_scale[7:0];
      `CACR_OFF_FSB_HI: d = c.input_b_full_scale[15:8];
      // reserved bits read as zero
      `CACR_OFF_REFSEL: d[`CACR_REFSEL_BIT] = c.reference_source_select;
      `CACR_OFF_TSCTRL: begin
        d[`CACR_TS_EN_BIT] = c.timestamp_receiver_enable;
        d[`CACR_TS_PECL_BIT] = c.timestamp_pecl_mode;
      end
      `CACR_OFF_EMPH: begin
        d[`CACR_EMPH_LVL_MSB:`CACR_EMPH_LVL_LSB] = c.lane_emphasis_level;
        d[`CACR_EMPH_BOOST_BIT] = c.lane_emphasis_boost;
      end
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_addr = addr;
    next_rw = rw;
    next_tx = tx;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    next_ctrl = ctrl;
    next_pos = pos;
    next_pos_valid = sync_pos_valid;
    wr_commit = 1'b0;
    wdata = {shift[6:0], pins.sdi};
    // only the measurement path loads the position; host writes never do
    if (sync_pos_strobe) begin
      next_pos = sync_pos_value;
      next_pos_valid = 1'b1;
    end
    if (pins.cs_n) begin
      next_state = st_idle;
      next_cnt = 5'h00;
      next_sdo_oe = 1'b0;
      next_sdo = 1'b0;
    end else begin
      case (state)
        st_idle: begin
          next_state = st_cmd;
          next_cnt = 5'h00;
        end
        st_cmd: begin
          if (rise) begin
            next_shift = {shift[14:0], pins.sdi};
            next_cnt = cnt + 5'h01;
            if (cnt == `CACR_CMD_BITS - 5'h01) begin
              next_rw = shift[`CACR_RW_BIT-1];
              next_addr = cmd_addr;
              next_tx = rd_byte(cmd_addr, ctrl, pos);
              next_cnt = 5'h00;
              next_state = st_data;
            end
          end
        end
        st_data: begin
          if (fall) begin
            next_sdo = tx[7];
            next_tx = {tx[6:0], 1'b0};
            next_sdo_oe = rw;
          end
          if (rise) begin
            next_shift = {shift[14:0], pins.sdi};
            next_cnt = cnt + 5'h01;
            if (cnt == `CACR_DATA_BITS - 5'h01) begin
              next_cnt = 5'h00;
              next_addr = addr + 15'h0001;
              wr_commit = ~rw;
              next_tx = rd_byte(addr + 15'h0001, ctrl, pos);
            end
          end
        end
        default: next_state = st_idle;
      endcase
    end
    if (wr_commit) begin
      case (addr)
        `CACR_OFF_FSA_LO: next_ctrl.input_a_full_scale[7:0] = wdata;
        `CACR_OFF_FSA_HI: next_ctrl.input_a_full_scale[15:8] = wdata;
        `CACR_OFF_FSB_LO: next_ctrl.input_b_full_scale[7:0] = wdata;
        `CACR_OFF_FSB_HI: next_ctrl.input_b_full_scale[15:8] = wdata;
        `CACR_OFF_REFSEL: next_ctrl.reference_source_select = wdata[`CACR_REFSEL_BIT];
        `CACR_OFF_TSCTRL: begin
          next_ctrl.timestamp_receiver_enable = wdata[`CACR_TS_EN_BIT];
          next_ctrl.timestamp_pecl_mode = wdata[`CACR_TS_PECL_BIT];
        end
        `CACR_OFF_EMPH: begin
          next_ctrl.lane_emphasis_level = wdata[`CACR_EMPH_LVL_MSB:`CACR_EMPH_LVL_LSB];
          next_ctrl.lane_emphasis_boost = wdata[`CACR_EMPH_BOOST_BIT];
        end
        // position bytes and unmapped offsets swallow the write
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev <= 1'b0;
      state <= st_idle;
      cnt <= 5'h00;
      shift <= 16'h0000;
      addr <= 15'h0000;
      rw <= 1'b0;
      tx <= 8'h00;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      ctrl.input_a_full_scale <= `CACR_FS_RESET;
      ctrl.input_b_full_scale <= `CACR_FS_RESET;
      ctrl.reference_source_select <= `CACR_BIT_RESET;
      ctrl.timestamp_receiver_enable <= `CACR_BIT_RESET;
      ctrl.timestamp_pecl_mode <= `CACR_BIT_RESET;
      ctrl.lane_emphasis_boost <= `CACR_BIT_RESET;
      ctrl.lane_emphasis_level <= `CACR_LVL_RESET;
      pos <= `CACR_POS_RESET;
      sync_pos_valid <= 1'b0;
    end else begin
      sclk_prev <= pins.sclk;
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      addr <= next_addr;
      rw <= next_rw;
      tx <= next_tx;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      ctrl <= next_ctrl;
      pos <= next_pos;
      sync_pos_valid <= next_pos_valid;
    end
  end

  // one copy per lane keeps fan-out local to each serializer
  genvar ln;
  generate
    for (ln = 0; ln < `CACR_LANES; ln++) begin : g_lane
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          lane_emphasis[4*ln +: 4] <= 4'h0;
        end else begin
          lane_emphasis[4*ln +: 4] <= {next_ctrl.lane_emphasis_boost, next_ctrl.lane_emphasis_level};
        end
      end
    end
  endgenerate

  pos_capture_a: assert property (@(posedge clk) disable iff (!nrst)
    sync_pos_strobe |=> pos == $past(sync_pos_value) && sync_pos_valid)
    else $error("edge position not captured");
  pos_readonly_a: assert property (@(posedge clk) disable iff (!nrst)
    !sync_pos_strobe |=> $stable(pos))
    else $error("edge position changed without measurement");
  valid_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    sync_pos_valid |=> sync_pos_valid)
    else $error("position valid dropped");
  pos_readback_a: assert property (@(posedge clk) disable iff (!nrst)
    (state == st_cmd && rise && cnt == 5'h0f && cmd_addr == `CACR_OFF_SYNC_POS0) |=> tx == $past(pos[7:0]))
    else $error("edge position readback wrong");
  oe_read_only_a: assert property (@(posedge clk) disable iff (!nrst)
    sdo_oe |-> rw && state == st_data)
    else $error("data out enabled outside a read");
  fsa_lo_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && addr == `CACR_OFF_FSA_LO) |=> ctrl.input_a_full_scale[7:0] == $past(wdata))
    else $error("input a full scale low write lost");
  fsa_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && addr == `CACR_OFF_FSA_HI) |=> ctrl.input_a_full_scale[15:8] == $past(wdata))
    else $error("input a full scale write lost");
  fsa_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_commit && (addr == `CACR_OFF_FSA_LO || addr == `CACR_OFF_FSA_HI)) |=> $stable(ctrl.input_a_full_scale))
    else $error("input a full scale moved without write");
  fsb_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && addr == `CACR_OFF_FSB_LO) |=> ctrl.input_b_full_scale[7:0] == $past(wdata))
    else $error("input b full scale write lost");
  fsb_hi_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && addr == `CACR_OFF_FSB_HI) |=> ctrl.input_b_full_scale[15:8] == $past(wdata))
    else $error("input b full scale high write lost");
  fsb_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_commit && (addr == `CACR_OFF_FSB_LO || addr == `CACR_OFF_FSB_HI)) |=> $stable(ctrl.input_b_full_scale))
    else $error("input b full scale moved without write");
  refsel_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && addr == `CACR_OFF_REFSEL) |=> ctrl.reference_source_select == $past(wdata[`CACR_REFSEL_BIT]))
    else $error("reference select write lost");
  refsel_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_commit && addr == `CACR_OFF_REFSEL) |=> $stable(ctrl.reference_source_select))
    else $error("reference select moved without write");
  ts_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && addr == `CACR_OFF_TSCTRL) |=>
      ctrl.timestamp_receiver_enable == $past(wdata[0]) && ctrl.timestamp_pecl_mode == $past(wdata[1]))
    else $error("timestamp control write lost");
  ts_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_commit && addr == `CACR_OFF_TSCTRL) |=> $stable({ctrl.timestamp_receiver_enable, ctrl.timestamp_pecl_mode}))
    else $error("timestamp control moved without write");
  emph_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_commit && addr == `CACR_OFF_EMPH) |=>
      ctrl.lane_emphasis_level == $past(wdata[2:0]) && ctrl.lane_emphasis_boost == $past(wdata[3]))
    else $error("emphasis write lost");
  emph_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_commit && addr == `CACR_OFF_EMPH) |=> $stable(lane_emphasis))
    else $error("lane emphasis moved without write");
  lane_fanout_a: assert property (@(posedge clk) disable iff (!nrst)
    lane_emphasis[4*(`CACR_LANES-1) +: 4] == {ctrl.lane_emphasis_boost, ctrl.lane_emphasis_level})
    else $error("lane emphasis differs from setting");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (state == st_cmd && rise && cnt == 5'h0f && cmd_addr == `CACR_OFF_EMPH) |=> tx[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
endmodule // cacr_regs
`default_nettype wire

// *** sim/cacr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cacr_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial port pins
  output logic sclk,
  output logic scs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  // read result
  output logic rd_done,
  output logic [31:0] rd_data
);
  logic busy;
  logic sdi_bit;
  logic idle_lvl;
  initial begin
    sclk = 1'b0;
    scs_n = 1'b1;
    sdi_bit = 1'b0;
    idle_lvl = 1'b0;
    busy = 1'b0;
    rd_done = 1'b0;
    rd_data = 32'h0;
  end
  // a released data line must not hold its last level; one driver keeps frame start race free
  always @(posedge clk) begin
    idle_lvl <= ~idle_lvl;
  end
  assign sdi = busy ? sdi_bit : idle_lvl;
  // six clocks per sclk level, above the four-clock minimum
  task automatic xfer(input logic [15:0] cmd, input logic [31:0] wd, input int nbits);
    logic [47:0] sh;
    logic [31:0] rd;
    int i;
    sh = {cmd, wd};
    rd = 32'h0;
    @(posedge clk);
    busy <= 1'b1;
    scs_n <= 1'b0;
    sdi_bit <= sh[47];
    repeat (6) @(posedge clk);
    for (i = 0; i < nbits; i++) begin
      if (i >= 16) rd = {rd[30:0], sdo};
      sclk <= 1'b1;
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
      sdi_bit <= (i < 47) ? sh[46-i] : 1'b0;
      repeat (6) @(posedge clk);
    end
    scs_n <= 1'b1;
    busy <= 1'b0;
    rd_data <= rd;
    rd_done <= cmd[15];
    @(posedge clk);
    rd_done <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // cacr_host_model
`default_nettype wire

// *** sim/cacr_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module cacr_regs_tb_top;
  import cacr_pkg::*;
  logic clk, nrst, sclk, scs_n, sdi, sdo, sdo_oe, strobe, pos_valid, rd_done;
  logic [23:0] pos_val;
  logic [31:0] rd_data;
  logic [63:0] lanes;
  logic [15:0] v, w;
  logic [7:0] b;
  cacr_ctrl_s ctrl, exp_ctrl;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int i;
  integer seed = 32'ha170ee04;

  cacr_regs u_cacr_regs (.clk(clk), .nrst(nrst), .sclk(sclk), .scs_n(scs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .sync_pos_strobe(strobe), .sync_pos_value(pos_val), .sync_pos_valid(pos_valid),
    .ctrl(ctrl), .lane_emphasis(lanes));
  cacr_host_model u_cacr_host_model (.clk(clk), .nrst(nrst), .sclk(sclk), .scs_n(scs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .rd_done(rd_done), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // write data is left aligned, first byte on top
  task automatic wr(input logic [14:0] a, input logic [31:0] d, input int nb);
    u_cacr_host_model.xfer({1'b0, a}, d, 16 + 8 * nb);
  endtask

  // expected read bytes are right aligned, last byte at the bottom
  task automatic rd(input logic [14:0] a, input int nb, input logic [31:0] e);
    exp_q.push_back(e);
    u_cacr_host_model.xfer({1'b1, a}, 32'h0, 16 + 8 * nb);
  endtask

  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("BAD %0t read with nothing expected", $time);
      end else chk({32'h0, rd_data}, {32'h0, exp_q.pop_front()});
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    nrst = 1'b0;
    strobe = 1'b0;
    pos_val = 24'h0;
    exp_ctrl = '0;
    exp_ctrl.input_a_full_scale = 16'ha000;
    exp_ctrl.input_b_full_scale = 16'ha000;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(ctrl, exp_ctrl);
    chk(lanes, 64'h0);
    chk({62'h0, sdo_oe, pos_valid}, 64'h0);
    rd(15'h0030, 4, 32'h00a000a0);
    for (i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'h2000 : (i == 1) ? 16'hffff : (16'($random(seed)) | 16'h2000);
      w = v ^ 16'h4000;
      wr(15'h0030, {v[7:0], v[15:8], w[7:0], w[15:8]}, 4);
      exp_ctrl.input_a_full_scale = v;
      exp_ctrl.input_b_full_scale = w;
      chk(ctrl, exp_ctrl);
      rd(15'h0030, 4, {v[7:0], v[15:8], w[7:0], w[15:8]});
    end
    // every level with and without boost; upper bits random to probe reserved bits
    for (i = 0; i < 16; i++) begin
      b = 8'($random(seed));
      b[3:0] = i[3:0];
      wr(15'h0038, {b, 24'h0}, 1);
      wr(15'h003b, {b, 24'h0}, 1);
      wr(15'h0048, {b, 24'h0}, 1);
      exp_ctrl.reference_source_select = b[0];
      exp_ctrl.timestamp_receiver_enable = b[0];
      exp_ctrl.timestamp_pecl_mode = b[1];
      exp_ctrl.lane_emphasis_boost = b[3];
      exp_ctrl.lane_emphasis_level = b[2:0];
      chk(ctrl, exp_ctrl);
      chk(lanes, {16{b[3:0]}});
      rd(15'h0038, 1, {31'h0, b[0]});
      rd(15'h003b, 1, {30'h0, b[1:0]});
      rd(15'h0048, 1, {28'h0, b[3:0]});
    end
    wr(15'h002c, 32'hffffff00, 3);
    wr(15'h0040, 32'hff000000, 1);
    u_cacr_host_model.xfer(16'h0048, 32'h5a000000, 20);
    chk(ctrl, exp_ctrl);
    chk({63'h0, pos_valid}, 64'h0);
    rd(15'h002c, 3, 32'h0);
    pos_val <= 24'($random(seed));
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk({63'h0, pos_valid}, 64'h1);
    // host reads the position before choosing its sync delay
    rd(15'h002c, 3, {8'h0, pos_val[7:0], pos_val[15:8], pos_val[23:16]});
    repeat (4) @(posedge clk);
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("BAD %0t reads missing", $time);
    end
    print_verdict();
  end
endmodule // cacr_regs_tb_top
`default_nettype wire
